// >>> hdl/port2_fault_pkg.sv
// =====================================================================
// Shared constants and carriers for the port 2 fault status flags.
// =====================================================================
package port2_fault_pkg;

  // =====================================================================
  // Register map.
  // =====================================================================
  // Byte address of the port 2 fault status register.
  localparam logic [7:0] STATUS2_ADDR  = 8'h04;
  // Field positions inside the status byte.
  localparam int         ERR_BIT       = 7;
  localparam int         LOW_V_BIT     = 4;
  localparam int         THERM_BIT     = 3;
  localparam int         UNIMP_BIT     = 2;
  localparam int         BACKBIAS_BIT  = 1;
  // Value of the status byte at reset.
  localparam logic [7:0] STATUS2_RST   = 8'h00;
  // Value returned for any other address.
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // =====================================================================
  // Analog thresholds and timing.
  // =====================================================================
  // Back-bias margin that the external comparator applies, in millivolts.
  localparam int         BACKBIAS_MARGIN_MV = 150;
  // Flip-flops in each pin synchroniser.
  localparam int         SYNC_STAGES        = 2;
  // Cycles after reset before synchronised pins are trusted.
  localparam logic [1:0] POWERUP_SETTLE     = 2'h2;

  // =====================================================================
  // Types.
  // =====================================================================
  // Error state of port 2.
  typedef enum logic {
    ST_ACTIVE = 1'b0,
    ST_ERROR  = 1'b1
  } port_state_e;

  // Comparator and control levels that feed the flags.
  typedef struct packed {
    logic below_min;     // Bus output under minimum bus voltage.
    logic backbias;      // Bus above source or core supply plus margin.
    logic temp_above;    // Die above the low shutdown threshold.
    logic temp_hold;     // Die above threshold minus hysteresis.
    logic cc_mode;       // Switch runs in constant-current mode.
    logic power_enable;  // Port 2 power enable control.
    logic other_fault;   // Any other port 2 fault still present.
  } fault_cond_s;

endpackage : port2_fault_pkg

// >>> hdl/level_sync.sv
`timescale 1ns/10ps
// =====================================================================
// Two-stage synchroniser for a vector of unrelated slow levels.
// =====================================================================
module level_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels in and out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Refuse at elaboration a width that leaves nothing to synchronise.
  if (WIDTH < 1) begin : g_bad_width
    $error("level_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] meta_ff;  // First stage, read only by the second.
  logic [WIDTH-1:0] sync_ff;  // Second stage, safe to use.

  // Each bit is an independent level, so no word coherence is promised.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : level_sync

// >>> hdl/port2_fault_status_flags.sv
`timescale 1ns/10ps
module port2_fault_status_flags (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port from the serial interface engine, same clock.
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_ff,
  // Asynchronous comparator and control pins.
  input  wire logic       vbus2_below_min,
  input  wire logic       vbus2_backbias,
  input  wire logic       die_above_low,
  input  wire logic       die_above_release,
  input  wire logic       cc_mode,
  input  wire logic       port2_power_enable,
  input  wire logic       port2_other_fault,
  // Port status outputs.
  output logic            port2_alert_n_ff,
  output logic            port2_error_ff
);

  // =====================================================================
  // Pin synchronisation.
  // =====================================================================
  port2_fault_pkg::fault_cond_s cond;       // Synchronised levels.
  logic [6:0]                   cond_vec;   // Same levels as a vector.

  level_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({vbus2_below_min, vbus2_backbias, die_above_low,
                die_above_release, cc_mode, port2_power_enable,
                port2_other_fault}),
    .sync_out (cond_vec)
  );

  assign cond = port2_fault_pkg::fault_cond_s'(cond_vec);

  // =====================================================================
  // Decode of register accesses.
  // =====================================================================
  logic rd_hit;     // Read of the status register this cycle.
  logic wr_zero;    // Write with bit 7 zero that asks to clear the error flag.
  logic pen_rise;   // Power enable went from inactive to active.
  logic pen_fall;   // Power enable dropped, which also clears errors.
  logic err_clear;  // Error flag is being cleared this cycle.
  logic any_cond;   // Some fault condition still present.
  logic tw_qual;    // Thermal warning may raise alert and error.

  assign rd_hit   = reg_rd && (reg_addr == port2_fault_pkg::STATUS2_ADDR);
  assign wr_zero  = reg_wr && (reg_addr == port2_fault_pkg::STATUS2_ADDR) &&
                    !reg_wdata[port2_fault_pkg::ERR_BIT];
  assign any_cond = cond.below_min || cond.backbias || cond.other_fault;

  // Status byte as software sees it; other port bits live elsewhere.
  function automatic logic [7:0] status_byte(input logic err, input logic ko,
                                             input logic tw, input logic bb);
    logic [7:0] s;
    s = port2_fault_pkg::STATUS2_RST;
    s[port2_fault_pkg::ERR_BIT]      = err;
    s[port2_fault_pkg::LOW_V_BIT]    = ko;
    s[port2_fault_pkg::THERM_BIT]    = tw;
    s[port2_fault_pkg::UNIMP_BIT]    = 1'b0;
    s[port2_fault_pkg::BACKBIAS_BIT] = bb;
    return s;
  endfunction : status_byte

  // =====================================================================
  // Flag and state registers.
  // =====================================================================
  logic                         ko_ff,       nxt_ko;        // Keep-out flag.
  logic                         bb_ff,       nxt_bb;        // Back-bias flag.
  logic                         tw_ff,       nxt_tw;        // Thermal flag.
  logic                         pen_prev_ff, nxt_pen_prev;  // Enable history.
  logic                         pwrup_ff,    nxt_pwrup;     // Power-up window.
  logic [1:0]                   settle_ff,   nxt_settle;    // Settle counter.
  port2_fault_pkg::port_state_e state_ff,    nxt_state;     // Active or error.
  logic [7:0]                   nxt_rdata;                  // Read data.
  logic                         nxt_alert_n;                // Alert pin.
  logic                         nxt_error;                  // Error output.

  // Enable edges come from synchronised levels only. After a reset with the
  // enable already high the history is low, so one rise is seen; it falls on
  // the same cycle as the power-up qualification and is therefore harmless.
  assign pen_rise = cond.power_enable && !pen_prev_ff;
  assign pen_fall = !cond.power_enable && pen_prev_ff;

  // The power-up check waits for the synchronisers to fill, otherwise the
  // reset zeros would hide an enable pin that was already active.
  assign tw_qual = cond.temp_above &&
                   (cond.cc_mode || pen_rise ||
                    (pwrup_ff && (settle_ff == port2_fault_pkg::POWERUP_SETTLE) &&
                     cond.power_enable));

  // Error clears from software or from the enable dropping.
  assign err_clear = (state_ff == port2_fault_pkg::ST_ERROR) &&
                     ((wr_zero && !any_cond) || pen_fall);

  // Next values of all flags, the error state and the read data.
  always_comb begin
    // A still-present condition re-sets the flag, so a set beats a clear.
    nxt_ko = cond.below_min || (ko_ff && !rd_hit && !err_clear);
    nxt_bb = cond.backbias || (bb_ff && !rd_hit && !err_clear);
    // Hysteresis: hold while the die stays above the release level.
    nxt_tw = cond.temp_above || (tw_ff && cond.temp_hold);
    nxt_pen_prev = cond.power_enable;
    nxt_settle   = settle_ff;
    nxt_pwrup    = pwrup_ff;
    if (settle_ff != port2_fault_pkg::POWERUP_SETTLE) begin
      nxt_settle = settle_ff + 2'h1;
    end else begin
      nxt_pwrup = 1'b0;
    end
    nxt_state = state_ff;
    unique case (state_ff)
      port2_fault_pkg::ST_ACTIVE: begin
        if (cond.below_min || cond.backbias || cond.other_fault || tw_qual) begin
          nxt_state = port2_fault_pkg::ST_ERROR;
        end
      end
      port2_fault_pkg::ST_ERROR: begin
        if (err_clear) begin
          nxt_state = port2_fault_pkg::ST_ACTIVE;
        end
      end
    endcase
    // Captures the values before this cycle's clear-on-read acts.
    if (rd_hit) begin
      nxt_rdata = status_byte(state_ff == port2_fault_pkg::ST_ERROR,
                              ko_ff, tw_ff, bb_ff);
    end else begin
      nxt_rdata = port2_fault_pkg::UNMAPPED_DATA;
    end
    nxt_alert_n = (nxt_state != port2_fault_pkg::ST_ERROR);
    // The error output mirrors the state so both outputs change together.
    nxt_error   = (nxt_state == port2_fault_pkg::ST_ERROR);
  end

  // Registers only; all decisions are made above.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ko_ff            <= 1'b0;
      bb_ff            <= 1'b0;
      tw_ff            <= 1'b0;
      pen_prev_ff      <= 1'b0;
      pwrup_ff         <= 1'b1;
      settle_ff        <= 2'h0;
      state_ff         <= port2_fault_pkg::ST_ACTIVE;
      reg_rdata_ff     <= port2_fault_pkg::STATUS2_RST;
      port2_alert_n_ff <= 1'b1;
      port2_error_ff   <= 1'b0;
    end else begin
      ko_ff            <= nxt_ko;
      bb_ff            <= nxt_bb;
      tw_ff            <= nxt_tw;
      pen_prev_ff      <= nxt_pen_prev;
      pwrup_ff         <= nxt_pwrup;
      settle_ff        <= nxt_settle;
      state_ff         <= nxt_state;
      reg_rdata_ff     <= nxt_rdata;
      port2_alert_n_ff <= nxt_alert_n;
      port2_error_ff   <= nxt_error;
    end
  end

  // =====================================================================
  // Assertions.
  // =====================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ko_set;
    cond.below_min |=> ko_ff && reg_rdata_ff[port2_fault_pkg::UNIMP_BIT] == 1'b0;
  endproperty
  a_ko_set: assert property (p_ko_set) else $error("keep-out flag missed");

  property p_bb_set;
    cond.backbias |=> bb_ff ##1
      (bb_ff || !cond.backbias || $past(rd_hit) || $past(err_clear));
  endproperty
  a_bb_set: assert property (p_bb_set) else $error("back-bias flag missed");

  property p_ko_clr;
    ko_ff && rd_hit && !cond.below_min |=> !ko_ff;
  endproperty
  a_ko_clr: assert property (p_ko_clr) else $error("keep-out not cleared");

  property p_bb_hold;
    bb_ff && !rd_hit && !err_clear |=> bb_ff;
  endproperty
  a_bb_hold: assert property (p_bb_hold) else $error("back-bias lost");

  property p_alert;
    (cond.below_min || cond.backbias) |=> !port2_alert_n_ff && port2_error_ff;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");

  property p_tw_release;
    tw_ff && !cond.temp_hold && !cond.temp_above |=> !tw_ff;
  endproperty
  a_tw_release: assert property (p_tw_release) else $error("thermal stuck");

  property p_tw_quiet;
    state_ff == port2_fault_pkg::ST_ACTIVE && !any_cond && !cond.cc_mode &&
      !pen_rise && !pwrup_ff |=> port2_alert_n_ff;
  endproperty
  a_tw_quiet: assert property (p_tw_quiet) else $error("thermal alert unqualified");

  property p_unimp;
    $rose(rd_hit) |=> reg_rdata_ff[port2_fault_pkg::UNIMP_BIT] == 1'b0;
  endproperty
  a_unimp: assert property (p_unimp) else $error("bit 2 read as one");

  property p_err_stay;
    state_ff == port2_fault_pkg::ST_ERROR && wr_zero && any_cond && !pen_fall
      |=> port2_error_ff;
  endproperty
  a_err_stay: assert property (p_err_stay) else $error("error left with fault");

  property p_rd_pre;
    rd_hit |=> reg_rdata_ff[port2_fault_pkg::LOW_V_BIT] == $past(ko_ff) &&
               reg_rdata_ff[port2_fault_pkg::BACKBIAS_BIT] == $past(bb_ff);
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("read not pre-clear");

  c_ko_read:   cover property (ko_ff && rd_hit && !cond.below_min);
  c_err_clr:   cover property (state_ff == port2_fault_pkg::ST_ERROR && wr_zero && !any_cond);
  c_tw_cc:     cover property (tw_qual && cond.cc_mode);
  c_tw_pwrup:  cover property (tw_qual && pwrup_ff);

endmodule : port2_fault_status_flags

// >>> tb/smbus_host_model.sv
`timescale 1ns/10ps
// =====================================================================
// Host side of the register port: single-byte reads and writes.
// =====================================================================
module smbus_host_model (
  // Clock.
  input  wire logic       clk,
  // Register port towards the flags block.
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_ff
);
  // Idle port at time zero, so no strobe is ever unknown.
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle read strobe; the byte stands only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    d        = reg_rdata_ff;
    reg_rd   = 1'b0;
    // A released address must not look like a valid one.
    reg_addr = ~a;
  endtask : rd

  // One-cycle write strobe; a zero in bit 7 asks for an error clear.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~v;
  endtask : wr
endmodule : smbus_host_model

// >>> tb/port2_fault_status_flags_tb.sv
`timescale 1ns/10ps
// =====================================================================
// Self-checking bench for the port 2 fault status flags.
// =====================================================================
module port2_fault_status_flags_tb;
  logic       clk, rst;                              // Clock and reset.
  logic       rd, wr;                                // Register strobes.
  logic [7:0] addr, wdata, rdata, got;               // Register bytes.
  logic       below_min, backbias, t_low, t_rel;     // Analog levels.
  logic       cc, pen, other, alert_n, err;          // Controls and outputs.
  int         fail_count, tests_run;                 // Tallies.

  port2_fault_status_flags dut (
    .clk(clk), .rst(rst), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_ff(rdata), .vbus2_below_min(below_min),
    .vbus2_backbias(backbias), .die_above_low(t_low), .die_above_release(t_rel),
    .cc_mode(cc), .port2_power_enable(pen), .port2_other_fault(other),
    .port2_alert_n_ff(alert_n), .port2_error_ff(err));

  smbus_host_model host (
    .clk(clk), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_ff(rdata));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare one byte and report a mismatch at once.
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  // Pins need two sync edges and one register edge; four leaves margin.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  // Read the status byte and compare it.
  task automatic rdchk(input logic [7:0] e, input string m);
    host.rd(8'h04, got);
    chk(got, e, m);
  endtask : rdchk

  // Compare the alert and error outputs together.
  task automatic st(input logic a, input logic e, input string m);
    chk({6'h00, alert_n, err}, {6'h00, a, e}, m);
  endtask : st

  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    fail_count = 0;
    tests_run  = 0;
    rst        = 1'b1;
    {below_min, backbias, t_low, t_rel, cc, pen, other} = 7'h00;
    repeat (2) @(posedge clk);
    #1;
    st(1'b1, 1'b0, "outputs in reset");
    rst = 1'b0;
    rdchk(8'h00, "reset value");
    host.rd(8'hA5, got);
    chk(got, 8'h00, "unmapped read");
    // Keep-out: set, hold while present, pre-clear read, then clear.
    below_min = 1'b1;
    settle;
    st(1'b0, 1'b1, "keep-out alert");
    rdchk(8'h90, "keep-out set");
    rdchk(8'h90, "keep-out held while present");
    below_min = 1'b0;
    settle;
    rdchk(8'h90, "pre-clear value");
    rdchk(8'h80, "keep-out cleared on read");
    host.wr(8'h04, 8'h80);
    st(1'b0, 1'b1, "bit 7 one ignored");
    host.wr(8'h04, 8'h00);
    st(1'b1, 1'b0, "error cleared");
    // Back-bias: a clear is refused while the fault stands.
    backbias = 1'b1;
    settle;
    rdchk(8'h82, "back-bias set");
    host.wr(8'h04, 8'h00);
    st(1'b0, 1'b1, "clear refused");
    backbias = 1'b0;
    settle;
    host.wr(8'h04, 8'h00);
    st(1'b1, 1'b0, "clear accepted");
    rdchk(8'h00, "flag gone with error clear");
    // Thermal warning without a qualifier raises no alert.
    {t_low, t_rel} = 2'h3;
    settle;
    rdchk(8'h08, "thermal set");
    st(1'b1, 1'b0, "no alert unqualified");
    t_low = 1'b0;
    settle;
    rdchk(8'h08, "hysteresis hold");
    t_rel = 1'b0;
    settle;
    rdchk(8'h00, "thermal released");
    // Constant-current mode qualifies the warning.
    {t_low, t_rel, cc} = 3'h7;
    settle;
    st(1'b0, 1'b1, "constant-current alert");
    {t_low, t_rel, cc} = 3'h0;
    settle;
    host.wr(8'h04, 8'h00);
    st(1'b1, 1'b0, "cleared after thermal");
    // Another port fault enters the error state and blocks its clear.
    other = 1'b1;
    settle;
    st(1'b0, 1'b1, "other fault error");
    host.wr(8'h04, 8'h00);
    st(1'b0, 1'b1, "clear refused by other fault");
    rdchk(8'h80, "only error bit for other fault");
    other = 1'b0;
    settle;
    host.wr(8'h04, 8'h00);
    st(1'b1, 1'b0, "clear after other fault");
    // Enable rising edge qualifies; falling edge clears the error.
    {t_low, t_rel} = 2'h3;
    settle;
    pen = 1'b1;
    settle;
    st(1'b0, 1'b1, "enable rise alert");
    pen = 1'b0;
    settle;
    st(1'b1, 1'b0, "enable fall clears");
    // Power-up with the enable already active.
    rst = 1'b1;
    pen = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    settle;
    st(1'b0, 1'b1, "power-up alert");
    tally_and_finish;
  end

  // Watchdog: the sequence needs well under a microsecond.
  initial begin
    #20000;
    fail_count++;
    tally_and_finish;
  end
endmodule : port2_fault_status_flags_tb
